// ==== tlih_pkg.sv ====
// Constants shared by the two-level interrupt handler files.
// How it works
// - Source condition sets its pending flag.
// - Request needs pending, source enable, global enable.
// - Core finishes instruction, then long-calls vector.
// - Return instruction resumes the interrupted program.
// - Disabled source's flag never causes a request.
// - Flags set whether or not enabled.
// - Hardware-cleared flags clear when core vectors.
// - Flag still set after return re-requests.
// - One independent enable bit per source.
// - Source enables count only with global enable.
// - Global enable low suppresses every request.
// - Masked interrupts stay pending until enabled.
// - Each source gets one of two levels.
// - Software flag write acts like hardware event.
// - High preempts low; high never preempted.
// - Higher level first, then fixed source order.
// - Decode each cycle; fastest response seven cycles.
// - Equal-or-lower waits past return plus one instruction.
`default_nettype none

package tlih_pkg;

	localparam int TLIH_NUM_SRC = 19;
	localparam int TLIH_VEC_W = 16;
	localparam logic [TLIH_VEC_W-1:0] TLIH_VEC_BASE = 16'h0003;
	localparam logic [TLIH_VEC_W-1:0] TLIH_VEC_STEP = 16'h0008;
	localparam logic [31:0] TLIH_HW_CLR_MASK = 32'h0000_000F;
	localparam int TLIH_RESP_MIN_CYCLES = 7;
	localparam logic TLIH_FLAG_RESET = 1'b0;
	localparam logic TLIH_LEVEL_RESET = 1'b0;

	typedef enum logic {
		TLIH_ST_IDLE,
		TLIH_ST_REQUEST
	} tlih_state_t;

endpackage

`default_nettype wire

// ==== tlih_flag_bank.sv ====
// Pending flag storage, one flip-flop per source.
`timescale 1ns/1ps
`default_nettype none

module tlih_flag_bank
	import tlih_pkg::*;
#(
	parameter int NUM_SRC = TLIH_NUM_SRC
) (
	input wire logic i_clock,
	input wire logic i_rst,
	input wire logic [NUM_SRC-1:0] i_set,
	input wire logic [NUM_SRC-1:0] i_clear,
	output logic [NUM_SRC-1:0] o_flag
);

	generate
		if (NUM_SRC < 1) begin : g_check
			$error("tlih_flag_bank: NUM_SRC must be at least 1");
		end
	endgenerate

	logic [NUM_SRC-1:0] next_flag;

	genvar g;
	generate
		for (g = 0; g < NUM_SRC; g++) begin : g_flag
			// A set in the same cycle as a clear wins, so no event is lost.
			always_comb begin
				next_flag[g] = (o_flag[g] & ~i_clear[g]) | i_set[g];
			end

			always_ff @(posedge i_clock) begin
				if (i_rst) begin
					o_flag[g] <= TLIH_FLAG_RESET;
				end else begin
					o_flag[g] <= next_flag[g];
				end
			end
		end
	endgenerate

endmodule

`default_nettype wire

// ==== tlih_arbiter.sv ====
// Two-level priority arbiter with fixed order inside a level.
`timescale 1ns/1ps
`default_nettype none

module tlih_arbiter
	import tlih_pkg::*;
#(
	parameter int NUM_SRC = TLIH_NUM_SRC,
	parameter int IDX_W = $clog2(TLIH_NUM_SRC)
) (
	input wire logic [NUM_SRC-1:0] i_cand,
	input wire logic [NUM_SRC-1:0] i_high,
	output logic o_valid,
	output logic [IDX_W-1:0] o_idx,
	output logic o_is_high
);

	// A narrower index could not name every source and would alias two of them.
	generate
		if (NUM_SRC < 1 || IDX_W < 1 || IDX_W < $clog2(NUM_SRC)) begin : g_check
			$error("tlih_arbiter: IDX_W too narrow for NUM_SRC");
		end
	endgenerate

	logic [NUM_SRC-1:0] cand_high;
	logic [NUM_SRC-1:0] pick_set;

	always_comb begin
		cand_high = i_cand & i_high;
		pick_set = (|cand_high) ? cand_high : i_cand;
		o_valid = |i_cand;
		o_is_high = |cand_high;
		o_idx = '0;
		// Walk from the top so the lowest index wins the tie.
		for (int k = NUM_SRC - 1; k >= 0; k--) begin
			if (pick_set[k]) begin
				o_idx = IDX_W'(k);
			end
		end
	end

endmodule

`default_nettype wire

// ==== tlih_handler.sv ====
// Two-level interrupt handler: flags, enables, arbitration and the core handshake.
`timescale 1ns/1ps
`default_nettype none

module tlih_handler
	import tlih_pkg::*;
#(
	parameter int NUM_SRC = TLIH_NUM_SRC,
	parameter logic [NUM_SRC-1:0] HW_CLR_MASK = TLIH_HW_CLR_MASK[NUM_SRC-1:0],
	parameter int IDX_W = $clog2(TLIH_NUM_SRC)
) (
	input wire logic i_clock,
	input wire logic i_rst,
	input wire logic [NUM_SRC-1:0] i_src_event,
	input wire logic [NUM_SRC-1:0] i_sw_flag_set,
	input wire logic [NUM_SRC-1:0] i_sw_flag_clear,
	input wire logic [NUM_SRC-1:0] i_src_enable,
	input wire logic i_global_irq_enable,
	input wire logic [NUM_SRC-1:0] i_src_high_priority,
	input wire logic i_instr_done,
	input wire logic i_interrupt_return_instruction_done,
	input wire logic i_irq_ack,
	output logic [NUM_SRC-1:0] o_pending,
	output logic o_irq_req,
	output logic [TLIH_VEC_W-1:0] o_vector,
	output logic [IDX_W-1:0] o_src_idx,
	output logic o_req_high,
	output logic o_active_low,
	output logic o_active_high,
	output logic o_interrupt_return_instruction_hold
);

	generate
		if (NUM_SRC < 2 || NUM_SRC > 32 || IDX_W != $clog2(NUM_SRC)) begin : g_check
			$error("tlih_handler: NUM_SRC must be 2..32 and IDX_W must be clog2(NUM_SRC)");
		end
	endgenerate

	tlih_state_t state;
	tlih_state_t next_state;
	logic next_irq_req;
	logic [TLIH_VEC_W-1:0] next_vector;
	logic [IDX_W-1:0] next_src_idx;
	logic next_req_high;
	logic next_active_low;
	logic next_active_high;
	logic next_interrupt_return_instruction_hold;

	logic [NUM_SRC-1:0] hw_clear;
	logic [NUM_SRC-1:0] flag_set;
	logic [NUM_SRC-1:0] flag_clear;
	logic [NUM_SRC-1:0] enabled;
	logic [NUM_SRC-1:0] level_ok;
	logic [NUM_SRC-1:0] cand;
	logic arb_valid;
	logic [IDX_W-1:0] arb_idx;
	logic arb_high;
	logic take_ack;

	// Hardware events and software writes of one both set the flag.
	always_comb begin
		flag_set = i_src_event | i_sw_flag_set;
		flag_clear = i_sw_flag_clear | hw_clear;
	end

	tlih_flag_bank #(
		.NUM_SRC(NUM_SRC)
	) u_flags (
		.i_clock(i_clock),
		.i_rst(i_rst),
		.i_set(flag_set),
		.i_clear(flag_clear),
		.o_flag(o_pending)
	);

	// Enables gate the candidates only; the flags themselves never see the enables,
	// so a masked interrupt simply waits in its flag until it is unmasked.
	always_comb begin
		enabled = o_pending & i_src_enable & {NUM_SRC{i_global_irq_enable}};
		if (o_active_high) begin
			level_ok = '0;
		end else if (o_active_low) begin
			level_ok = i_src_high_priority;
		end else begin
			level_ok = '1;
		end
		cand = enabled & level_ok & {NUM_SRC{~o_interrupt_return_instruction_hold}};
	end

	tlih_arbiter #(
		.NUM_SRC(NUM_SRC),
		.IDX_W(IDX_W)
	) u_arb (
		.i_cand(cand),
		.i_high(i_src_high_priority),
		.o_valid(arb_valid),
		.o_idx(arb_idx),
		.o_is_high(arb_high)
	);

	always_comb begin
		take_ack = (state == TLIH_ST_REQUEST) && i_irq_ack;
		hw_clear = '0;
		if (take_ack) begin
			// Only sources with a single unambiguous cause are cleared on vectoring.
			hw_clear[o_src_idx] = HW_CLR_MASK[o_src_idx];
		end
	end

	// Request sequencer. The request and vector are frozen while waiting for the
	// core, so a later, better request waits for the next decode rather than
	// changing the vector under a long call already in flight.
	always_comb begin
		next_state = state;
		next_irq_req = o_irq_req;
		next_vector = o_vector;
		next_src_idx = o_src_idx;
		next_req_high = o_req_high;
		case (state)
			TLIH_ST_IDLE: begin
				if (arb_valid) begin
					next_state = TLIH_ST_REQUEST;
					next_irq_req = 1'b1;
					next_src_idx = arb_idx;
					next_req_high = arb_high;
					next_vector = TLIH_VEC_BASE
						+ TLIH_VEC_W'(TLIH_VEC_STEP * TLIH_VEC_W'(arb_idx));
				end
			end
			TLIH_ST_REQUEST: begin
				if (i_irq_ack) begin
					next_state = TLIH_ST_IDLE;
					next_irq_req = 1'b0;
				end
			end
			default: begin
				next_state = TLIH_ST_IDLE;
				next_irq_req = 1'b0;
			end
		endcase
	end

	always_ff @(posedge i_clock) begin
		if (i_rst) begin
			state <= TLIH_ST_IDLE;
			o_irq_req <= 1'b0;
			o_vector <= '0;
			o_src_idx <= '0;
			o_req_high <= TLIH_LEVEL_RESET;
		end else begin
			state <= next_state;
			o_irq_req <= next_irq_req;
			o_vector <= next_vector;
			o_src_idx <= next_src_idx;
			o_req_high <= next_req_high;
		end
	end

	// In-service levels. A return with no ack in the same cycle closes the highest open level, which is
	// the routine that is running; the low level then carries on where it was.
	always_comb begin
		next_active_low = o_active_low;
		next_active_high = o_active_high;
		if (take_ack) begin
			if (o_req_high) begin
				next_active_high = 1'b1;
			end else begin
				next_active_low = 1'b1;
			end
		end else if (i_interrupt_return_instruction_done) begin
			if (o_active_high) begin
				next_active_high = 1'b0;
			end else begin
				next_active_low = 1'b0;
			end
		end
	end

	// After a return, one more instruction must complete before any new entry.
	always_comb begin
		next_interrupt_return_instruction_hold = o_interrupt_return_instruction_hold;
		if (i_interrupt_return_instruction_done) begin
			next_interrupt_return_instruction_hold = 1'b1;
		end else if (i_instr_done) begin
			next_interrupt_return_instruction_hold = 1'b0;
		end
	end

	always_ff @(posedge i_clock) begin
		if (i_rst) begin
			o_active_low <= 1'b0;
			o_active_high <= 1'b0;
			o_interrupt_return_instruction_hold <= 1'b0;
		end else begin
			o_active_low <= next_active_low;
			o_active_high <= next_active_high;
			o_interrupt_return_instruction_hold <= next_interrupt_return_instruction_hold;
		end
	end

endmodule

`default_nettype wire

// ==== tlih_handler_asserts.sv ====
// Port checker for the two-level interrupt handler.
`timescale 1ns/1ps
`default_nettype none
module tlih_handler_asserts import tlih_pkg::*; #(
	parameter int NUM_SRC = TLIH_NUM_SRC,
	parameter int IDX_W = 5
) (
	input wire logic i_clock,
	input wire logic i_rst,
	input wire logic [NUM_SRC-1:0] i_src_enable,
	input wire logic i_global_irq_enable,
	input wire logic i_irq_ack,
	input wire logic i_interrupt_return_instruction_done,
	input wire logic i_instr_done,
	input wire logic [NUM_SRC-1:0] o_pending,
	input wire logic o_irq_req,
	input wire logic [TLIH_VEC_W-1:0] o_vector,
	input wire logic [IDX_W-1:0] o_src_idx,
	input wire logic o_req_high,
	input wire logic o_active_low,
	input wire logic o_active_high,
	input wire logic o_interrupt_return_instruction_hold
);
	// Enabled flags as the decode saw them one edge before a request rose.
	logic [NUM_SRC-1:0] live;
	always_ff @(posedge i_clock) begin
		live <= o_pending & i_src_enable;
	end
	default clocking @(posedge i_clock); endclocking
	default disable iff (i_rst);
	sequence s_wait; o_irq_req && !i_irq_ack; endsequence
	sequence s_ret; i_interrupt_return_instruction_done ##1 o_interrupt_return_instruction_hold; endsequence
	sequence s_ready;
		!o_irq_req && !o_interrupt_return_instruction_hold && !o_active_low && !o_active_high && i_global_irq_enable
			&& (|(o_pending & i_src_enable));
	endsequence
	property p_hold; s_wait |=> o_irq_req && $stable(o_vector); endproperty
	property p_ack; o_irq_req && i_irq_ack |=> !o_irq_req; endproperty
	property p_vec;
		o_irq_req |-> o_vector == TLIH_VEC_BASE + TLIH_VEC_W'(TLIH_VEC_STEP * o_src_idx);
	endproperty
	property p_fast; s_ready |=> o_irq_req; endproperty
	property p_live; $rose(o_irq_req) |-> live[o_src_idx]; endproperty
	property p_glob; $rose(o_irq_req) |-> $past(i_global_irq_enable); endproperty
	property p_hi; $rose(o_irq_req) |-> !$past(o_active_high); endproperty
	property p_pre; $rose(o_irq_req) && $past(o_active_low) |-> o_req_high; endproperty
	property p_gap; $rose(o_irq_req) |-> !$past(o_interrupt_return_instruction_hold); endproperty
	property p_ret; i_interrupt_return_instruction_done |-> s_ret; endproperty
	property p_free; o_interrupt_return_instruction_hold && i_instr_done |=> !o_interrupt_return_instruction_hold; endproperty
	a_hold: assert property (p_hold) else $error("request not held");
	a_ack: assert property (p_ack) else $error("request kept after ack");
	a_vec: assert property (p_vec) else $error("wrong vector");
	a_glob: assert property (p_glob) else $error("request without global");
	a_hi: assert property (p_hi) else $error("high routine preempted");
	a_pre: assert property (p_pre) else $error("low level preempted low");
	a_gap: assert property (p_gap) else $error("no instruction after return");
	a_ret: assert property (p_ret) else $error("return not tracked");
	a_free: assert property (p_free) else $error("hold stuck");
	a_fast: assert property (p_fast) else $error("request not raised next cycle");
	a_live: assert property (p_live) else $error("request from disabled source");
endmodule
bind tlih_handler tlih_handler_asserts #(.NUM_SRC(NUM_SRC), .IDX_W(IDX_W)) u_chk (
	.i_clock(i_clock), .i_rst(i_rst), .i_src_enable(i_src_enable), .o_pending(o_pending),
	.i_global_irq_enable(i_global_irq_enable), .i_irq_ack(i_irq_ack),
	.i_interrupt_return_instruction_done(i_interrupt_return_instruction_done), .i_instr_done(i_instr_done), .o_irq_req(o_irq_req),
	.o_vector(o_vector), .o_src_idx(o_src_idx), .o_req_high(o_req_high),
	.o_active_low(o_active_low), .o_active_high(o_active_high), .o_interrupt_return_instruction_hold(o_interrupt_return_instruction_hold));
`default_nettype wire

// ==== tlih_core_model.sv ====
// Core sequencer model that acks requests and runs returns.
`timescale 1ns/1ps
`default_nettype none
module tlih_core_model (
	input wire logic i_clock,
	input wire logic i_rst,
	input wire logic i_req,
	input wire logic i_ret,
	input wire logic [1:0] i_dly,
	output logic o_ack = 1'b0,
	output logic o_interrupt_return_instruction = 1'b0,
	output logic o_instr = 1'b0
);
	logic [1:0] cnt = 2'h0;
	always @(posedge i_clock) begin
		o_ack <= 1'b0;
		o_interrupt_return_instruction <= 1'b0;
		o_instr <= 1'b0;
		if (i_rst) begin
			cnt <= 2'h0;
		end else if (i_ret) begin
			o_interrupt_return_instruction <= 1'b1;
		end else if (o_interrupt_return_instruction) begin
			o_instr <= 1'b1;
		end else if (i_req && !o_ack) begin
			cnt <= cnt + 2'h1;
			// A slow ack mimics a long instruction still in progress.
			if (cnt >= i_dly) begin
				o_ack <= 1'b1;
				cnt <= 2'h0;
			end
		end
	end
endmodule
`default_nettype wire

// ==== tlih_handler_tb.sv ====
// Self-checking testbench for the two-level interrupt handler.
`timescale 1ns/1ps
`default_nettype none
module tlih_handler_tb import tlih_pkg::*;;
	localparam int N = TLIH_NUM_SRC;
	logic i_clock = 0, i_rst = 1, ge = 0, ret = 0, ack, rti, ins, req, rh, al, ah, hold;
	logic [N-1:0] ev = '0, ss = '0, sc = '0, en = '0, hi = '0, pend;
	logic [15:0] vec, want, q[$];
	logic [4:0] idx;
	logic [1:0] dly = 2'h0;
	int failures = 0, compares = 0, cyc = 0;
	bit seen = 0;
	always #2 i_clock = ~i_clock;
	tlih_handler dut (.i_clock(i_clock), .i_rst(i_rst), .i_src_event(ev), .i_sw_flag_set(ss),
		.i_sw_flag_clear(sc), .i_src_enable(en), .i_global_irq_enable(ge),
		.i_src_high_priority(hi), .i_instr_done(ins), .i_interrupt_return_instruction_done(rti), .i_irq_ack(ack),
		.o_pending(pend), .o_irq_req(req), .o_vector(vec), .o_src_idx(idx), .o_req_high(rh),
		.o_active_low(al), .o_active_high(ah), .o_interrupt_return_instruction_hold(hold));
	tlih_core_model core (.i_clock(i_clock), .i_rst(i_rst), .i_req(req), .i_ret(ret),
		.i_dly(dly), .o_ack(ack), .o_interrupt_return_instruction(rti), .o_instr(ins));
	function automatic logic [15:0] vf(int n);
		return TLIH_VEC_BASE + TLIH_VEC_W'(n * TLIH_VEC_STEP);
	endfunction
	task automatic tick(int k);
		repeat (k) @(posedge i_clock);
	endtask
	task automatic chk(logic [15:0] s, logic [15:0] e);
		compares++;
		if (s !== e) begin
			failures++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask
	task automatic end_sim;
		$display("failures=%0d compares=%0d", failures, compares);
		if (failures == 0 && compares > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	task automatic pulse(int n);
		ev[n] <= 1'b1;
		tick(1);
		ev <= '0;
	endtask
	task automatic wack(int n);
		int k;
		k = 0;
		while (ack !== 1'b1 && k < 50) begin
			tick(1);
			k++;
		end
		if (k == 50) failures++;
		tick(2);
		chk(16'(pend[n]), 16'(!TLIH_HW_CLR_MASK[n]));
	endtask
	task automatic fin(int n, bit clr);
		if (clr) sc[n] <= 1'b1;
		tick(1);
		sc <= '0;
		ret <= 1'b1;
		tick(1);
		ret <= 1'b0;
		// A pending re-entry is acked within a few edges, so wack must already be watching.
		tick(2);
	endtask
	// Each rising request takes the oldest expected vector.
	always @(posedge i_clock) begin
		if (!req) seen = 0;
		else if (!seen && !i_rst) begin
			seen = 1;
			if (q.size() > 0) begin
				want = q.pop_front();
				chk(vec, want);
				chk(TLIH_VEC_BASE + TLIH_VEC_STEP * 16'(idx), want);
			end else chk(vec, 16'hffff);
		end
	end
	always @(posedge i_clock) begin
		cyc++;
		if (cyc == 20000) begin
			failures++;
			end_sim();
		end
	end
	initial begin
		bit r;
		void'($urandom(32'h0000_de98));
		tick(16);
		i_rst <= 1'b0;
		en <= '1;
		ge <= 1'b1;
		for (int n = 0; n < N; n++) begin
			r = 1'($urandom);
			dly <= 2'($urandom);
			q.push_back(vf(n));
			ev[n] <= r;
			ss[n] <= !r;
			tick(1);
			ev <= '0;
			ss <= '0;
			wack(n);
			fin(n, 1'b1);
		end
		$display("done: every source");
		q.push_back(vf(6));
		q.push_back(vf(6));
		pulse(6);
		wack(6);
		fin(6, 1'b0);
		wack(6);
		fin(6, 1'b1);
		$display("done: re-entry");
		ge <= 1'b0;
		pulse(5);
		tick(4);
		chk(16'(req), 16'h0000);
		chk(16'(pend[5]), 16'h0001);
		en[5] <= 1'b0;
		ge <= 1'b1;
		tick(4);
		chk(16'(req), 16'h0000);
		q.push_back(vf(5));
		en[5] <= 1'b1;
		wack(5);
		fin(5, 1'b1);
		$display("done: masking");
		hi[7] <= 1'b1;
		q.push_back(vf(7));
		q.push_back(vf(10));
		q.push_back(vf(12));
		ev[12] <= 1'b1;
		ev[10] <= 1'b1;
		pulse(7);
		wack(7);
		fin(7, 1'b1);
		wack(10);
		fin(10, 1'b1);
		wack(12);
		fin(12, 1'b1);
		$display("done: arbitration");
		hi <= 19'h0_0008;
		q.push_back(vf(9));
		q.push_back(vf(3));
		pulse(9);
		wack(9);
		pulse(3);
		wack(3);
		chk(16'({ah, al}), 16'h0003);
		chk(16'(rh), 16'h0001);
		fin(3, 1'b1);
		fin(9, 1'b1);
		$display("done: preemption");
		chk(16'(q.size()), 16'h0000);
		end_sim();
	end
endmodule
`default_nettype wire
